// ===== hw/lowfreq_wakeup_timer_capture.sv
// module: low-frequency wakeup timer with compare and capture
// assumes the mcu sfr bus on i_clk_sys and the lf clock on a pin
`timescale 1ns/1ps
module lowfreq_wakeup_timer_capture (
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   input wire rtc_wakeup_pkg::sfr_req_s i_sfr,
   output logic [7:0] o_sfr_rdata,
   output logic o_sfr_hit,
   input wire logic i_low_freq_clock,
   input wire logic i_radio_irq,
   input wire rtc_wakeup_pkg::osc_status_s i_osc,
   output logic o_wakeup_irq,
   output logic o_wake_request,
   output logic o_rc_clock_select,
   output logic o_core_clock_run
);
   // register file
   // fields live in separate flops, not a packed byte
   // read path assembles the config byte on demand
   logic enable_reg; // lowfreq_timer_enable
   logic [1:0] mode_reg; // compare_behaviour
   logic radio_en_reg; // radio_capture_enable
   logic [7:0] cmp_low_reg; // compare_low
   logic [7:0] cmp_high_reg; // compare_high
   logic [7:0] cpt_low_reg; // capture_low
   logic [7:0] cpt_high_reg; // capture_high
   logic [7:0] cpt_fine_reg; // capture_fine
   // timer state
   // everything below runs on the mcu clock only
   // the lf clock arrives as a synchronised tick
   logic [15:0] timer_reg; // lf timer
   logic [15:0] timer_next; // next timer value
   logic [rtc_wakeup_pkg::FINE_W-1:0] fine_reg; // mcu cycles since lf edge
   logic [rtc_wakeup_pkg::FINE_W-1:0] fine_next; // next fine value
   logic irq_reg; // wakeup pulse
   logic [7:0] rdata_reg; // read data
   logic hit_reg; // read hit
   // retention lead selection
   // lead is chosen once per retention entry
   // later oscillator changes do not move it
   logic retention_last_reg; // retention seen last cycle
   logic short_lead_reg; // lead latched at entry
   // decoded strobes
   // all single-cycle, the write strobes valid only in the bus cycle
   // nothing here is stored between cycles
   logic wr_config; // write to rtc_config
   logic wr_cmp_low; // write to compare_low
   logic wr_cmp_high; // write to compare_high
   logic soft_trig; // software capture strobe
   logic radio_trig; // radio capture strobe
   logic capture; // any capture event
   // synchronised pins
   // only the rising pulses are used, levels left open
   logic lf_rise; // lf rising edge pulse
   logic radio_rise; // radio rising edge pulse
   // derived
   // combinational views of the register file and oscillator status
   // no state of their own
   logic [15:0] compare_value; // effective compare word
   logic lf_tick; // gated lf tick
   logic match; // compare hit on this tick
   logic armed; // compare interrupt enabled
   logic rc_enabled; // fast rc oscillator on
   logic rc_only; // rc on, crystal off
   logic short_at_entry; // short lead condition now

   // lf clock pin enters the mcu domain through two flops
   pin_edge_sync u_lf_sync (
      .i_clk_sys(i_clk_sys),
      .i_arst_n(i_arst_n),
      .i_pin(i_low_freq_clock),
      .o_level(),
      .o_rise(lf_rise)
   );

   // radio interrupt pin, edge detected on the mcu clock
   pin_edge_sync u_radio_sync (
      .i_clk_sys(i_clk_sys),
      .i_arst_n(i_arst_n),
      .i_pin(i_radio_irq),
      .o_level(),
      .o_rise(radio_rise)
   );

   // write decode on the sfr bus
   // one access per cycle, strobes are single-cycle
   // writes to read-only or unknown addresses fall through
   // a config write with bit 4 set also captures
   // radio edge only counts while capture is enabled
   always_comb begin
      wr_config = i_sfr.wr && (i_sfr.addr == rtc_wakeup_pkg::ADDR_RTC_CONFIG);
      wr_cmp_low = i_sfr.wr && (i_sfr.addr == rtc_wakeup_pkg::ADDR_COMPARE_LOW);
      wr_cmp_high = i_sfr.wr && (i_sfr.addr == rtc_wakeup_pkg::ADDR_COMPARE_HIGH);
      // trigger exists only in the write cycle
      soft_trig = wr_config && i_sfr.wdata[rtc_wakeup_pkg::CFG_SOFT_BIT];
      radio_trig = radio_en_reg && radio_rise;
      capture = soft_trig || radio_trig;
   end

   // compare word is live from the byte registers
   // a half-written word is compared as it stands
   // software masks the interrupt across the two writes
   // match is sampled only on a gated lf tick
   // disabled core never arms the compare
   always_comb begin
      compare_value = {cmp_high_reg, cmp_low_reg};
      lf_tick = enable_reg && lf_rise;
      armed = enable_reg && (mode_reg[1] == 1'b1);
      // checked once per lf period, so a new value may lag one period
      match = lf_tick && armed && (timer_reg == compare_value);
   end

   // next timer value
   // hold by default, advance on each lf tick
   // match in mode 11 restarts from zero
   // mode 10 and modes 0x simply roll over at the top
   always_comb begin
      timer_next = timer_reg;
      if (!enable_reg) begin
         // disabled core holds the timer at zero
         timer_next = rtc_wakeup_pkg::TIMER_RESET;
      end else if (lf_tick) begin
         if (match && (mode_reg == rtc_wakeup_pkg::MODE_RESET)) begin
            // restart so the period is compare plus one ticks
            timer_next = rtc_wakeup_pkg::TIMER_RESET;
         end else begin
            // wraps naturally at overflow
            timer_next = timer_reg + 16'h0001;
         end
      end
   end

   // low-frequency timer
   // single register, updated only in the mcu domain
   // the lf clock never clocks a flop directly
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         timer_reg <= rtc_wakeup_pkg::TIMER_RESET;
      end else begin
         timer_reg <= timer_next;
      end
   end

   // next fine count
   // restart at every synchronised lf edge
   // two-flop latency shifts the origin by a fixed amount
   // saturation keeps a missing lf clock from wrapping
   always_comb begin
      fine_next = fine_reg;
      if (lf_rise) begin
         // restart at each lf rising edge seen in mcu domain
         fine_next = rtc_wakeup_pkg::FINE_ZERO;
      end else if (fine_reg != rtc_wakeup_pkg::FINE_SAT) begin
         // counts mcu cycles, stops at FINE_SAT (10'h1ff) to avoid wrap
         fine_next = fine_reg + rtc_wakeup_pkg::FINE_ONE;
      end
   end

   // fine mcu-cycle counter
   // free running, independent of the enable bit
   // so a capture right after enabling still has a value
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         fine_reg <= rtc_wakeup_pkg::FINE_ZERO;
      end else begin
         fine_reg <= fine_next;
      end
   end

   // wakeup interrupt pulse
   // registered one cycle after the match
   // width is always one mcu cycle
   // the interrupt controller latches the pulse
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         irq_reg <= 1'b0;
      end else begin
         // one cycle per match, modes 10 and 11 only
         irq_reg <= match;
      end
   end

   // configuration fields
   // enable, mode and radio bits share one write
   // trigger bit is not stored here
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         enable_reg <= 1'b0;
         mode_reg <= rtc_wakeup_pkg::MODE_OFF0;
         radio_en_reg <= 1'b0;
      end else if (wr_config) begin
         enable_reg <= i_sfr.wdata[rtc_wakeup_pkg::CFG_ENABLE_BIT];
         mode_reg <= i_sfr.wdata[rtc_wakeup_pkg::CFG_MODE_MSB:rtc_wakeup_pkg::CFG_MODE_LSB];
         radio_en_reg <= i_sfr.wdata[rtc_wakeup_pkg::CFG_RADIO_BIT];
      end
   end

   // compare bytes, each write takes effect at once
   // no shadow register: each byte applies alone
   // a spurious match between writes is the caller's risk
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cmp_low_reg <= rtc_wakeup_pkg::COMPARE_RESET;
         cmp_high_reg <= rtc_wakeup_pkg::COMPARE_RESET;
      end else begin
         if (wr_cmp_low) begin
            cmp_low_reg <= i_sfr.wdata;
         end
         if (wr_cmp_high) begin
            cmp_high_reg <= i_sfr.wdata;
         end
      end
   end

   // capture registers, written only by capture events
   // software and radio triggers share one path
   // the three bytes always load together
   // bus writes never reach these registers
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cpt_low_reg <= rtc_wakeup_pkg::CAPTURE_RESET;
         cpt_high_reg <= rtc_wakeup_pkg::CAPTURE_RESET;
         cpt_fine_reg <= rtc_wakeup_pkg::CAPTURE_RESET;
      end else if (capture) begin
         cpt_low_reg <= timer_reg[7:0];
         cpt_high_reg <= timer_reg[15:8];
         // lsb dropped for half-rate resolution
         cpt_fine_reg <= fine_reg[8:1];
      end
   end

   // oscillator conditions for the pre-start lead
   // rc enabled by either clock_control rc bit
   // short lead when rc alone must start
   // or when the crystal keeps running in retention
   always_comb begin
      rc_enabled = |i_osc.clock_control[rtc_wakeup_pkg::CLOCK_CONTROL_REG_RC_MSB:rtc_wakeup_pkg::CLOCK_CONTROL_REG_RC_LSB];
      rc_only = rc_enabled && !i_osc.xtal_enabled;
      // crystal kept in retention and already running
      short_at_entry = rc_only
         || (i_osc.clock_control[rtc_wakeup_pkg::CLOCK_CONTROL_REG_KEEP_BIT] && i_osc.xtal_running);
   end

   // lead chosen when retention is entered
   // entry edge found on the same-domain level
   // lead frozen for the whole retention stay
   // a crystal still starting up forces the long lead
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         retention_last_reg <= 1'b0;
         short_lead_reg <= 1'b0;
      end else begin
         retention_last_reg <= i_osc.retention;
         if (i_osc.retention && !retention_last_reg) begin
            // crystal not yet up at entry falls back to long
            short_lead_reg <= short_at_entry;
         end
      end
   end

   // early wake of the mcu ahead of the match
   // armed only in compare modes 10 and 11
   // wake request is a level, cleared after the match
   wake_prestart u_prestart (
      .i_clk_sys(i_clk_sys),
      .i_arst_n(i_arst_n),
      .i_armed(armed),
      .i_retention(i_osc.retention),
      .i_short_lead(short_lead_reg),
      .i_timer(timer_reg),
      .i_compare(compare_value),
      .o_wake_req(o_wake_request)
   );

   // register read path, answer one cycle after the strobe
   // data and hit stand for exactly one cycle
   // zero data when idle keeps an or-ed bus clean
   // reads have no side effects on any register
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rdata_reg <= rtc_wakeup_pkg::READ_ZERO;
         hit_reg <= 1'b0;
      end else begin
         hit_reg <= 1'b0;
         rdata_reg <= rtc_wakeup_pkg::READ_ZERO;
         if (i_sfr.rd) begin
            hit_reg <= 1'b1;
            case (i_sfr.addr)
               rtc_wakeup_pkg::ADDR_RTC_CONFIG: begin
                  // trigger bit always reads zero
                  rdata_reg <= {3'h0, 1'b0, radio_en_reg, mode_reg, enable_reg};
               end
               rtc_wakeup_pkg::ADDR_COMPARE_LOW: begin
                  rdata_reg <= cmp_low_reg;
               end
               rtc_wakeup_pkg::ADDR_COMPARE_HIGH: begin
                  rdata_reg <= cmp_high_reg;
               end
               rtc_wakeup_pkg::ADDR_CAPTURE_LOW: begin
                  rdata_reg <= cpt_low_reg;
               end
               rtc_wakeup_pkg::ADDR_CAPTURE_HIGH: begin
                  rdata_reg <= cpt_high_reg;
               end
               rtc_wakeup_pkg::ADDR_CAPTURE_FINE: begin
                  rdata_reg <= cpt_fine_reg;
               end
               default: begin
                  // not ours: no hit, zero data
                  hit_reg <= 1'b0;
               end
            endcase
         end
      end
   end

   // outputs
   // all outputs from flops except rc select
   // rc select follows the registered wake request
   assign o_sfr_rdata = rdata_reg;
   assign o_sfr_hit = hit_reg;
   assign o_wakeup_irq = irq_reg;
   assign o_core_clock_run = enable_reg;
   // rc oscillator clocks the mcu while pre-starting
   assign o_rc_clock_select = o_wake_request && rc_enabled;
endmodule

// ===== hw/rtc_wakeup_pkg.sv
// package: addresses, fields, reset values and timing of the wakeup timer
// assumes an 8-bit special-function-register bus from the mcu core
package rtc_wakeup_pkg;
   // register addresses on the sfr bus
   localparam logic [7:0] ADDR_CAPTURE_HIGH = 8'hab;
   localparam logic [7:0] ADDR_CAPTURE_FINE = 8'hac;
   localparam logic [7:0] ADDR_RTC_CONFIG = 8'hb3;
   localparam logic [7:0] ADDR_COMPARE_LOW = 8'hb4;
   localparam logic [7:0] ADDR_COMPARE_HIGH = 8'hb5;
   localparam logic [7:0] ADDR_CAPTURE_LOW = 8'hb6;
   // rtc_config field positions
   localparam int CFG_ENABLE_BIT = 0;
   localparam int CFG_MODE_LSB = 1;
   localparam int CFG_MODE_MSB = 2;
   localparam int CFG_RADIO_BIT = 3;
   localparam int CFG_SOFT_BIT = 4;
   // clock_control fields seen by the block
   localparam int CLOCK_CONTROL_REG_RC_LSB = 4;
   localparam int CLOCK_CONTROL_REG_RC_MSB = 5;
   localparam int CLOCK_CONTROL_REG_KEEP_BIT = 7;
   // reset values
   localparam logic [7:0] COMPARE_RESET = 8'hff;
   localparam logic [7:0] CAPTURE_RESET = 8'h00;
   localparam logic [15:0] TIMER_RESET = 16'h0000;
   localparam logic [7:0] READ_ZERO = 8'h00;
   // pre-start leads in low-frequency periods
   localparam logic [15:0] LEAD_LONG = 16'h0031;
   localparam logic [15:0] LEAD_SHORT = 16'h0002;
   // timing: low-frequency period and system clock period
   localparam int LF_PERIOD_NS = 30520;
   localparam int SYS_PERIOD_NS = 40;
   localparam int FINE_MAX_CYCLES = LF_PERIOD_NS / SYS_PERIOD_NS;
   localparam int FINE_W = 10;
   localparam logic [FINE_W-1:0] FINE_ONE = 10'h001;
   localparam logic [FINE_W-1:0] FINE_ZERO = 10'h000;
   localparam logic [FINE_W-1:0] FINE_SAT = 10'h1ff;
   // compare behaviour encodings
   typedef enum logic [1:0] {
      MODE_OFF0 = 2'b00,
      MODE_OFF1 = 2'b01,
      MODE_KEEP = 2'b10,
      MODE_RESET = 2'b11
   } cmp_mode_e;
   // sfr bus request from the mcu
   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } sfr_req_s;
   // oscillator and power state from the power-mode controller
   typedef struct packed {
      logic retention;
      logic xtal_enabled;
      logic xtal_running;
      logic [7:0] clock_control;
   } osc_status_s;
endpackage

// ===== hw/pin_edge_sync.sv
// module: two-flop synchroniser with a rising-edge pulse
// assumes the input comes from outside the i_clk_sys domain
`timescale 1ns/1ps
module pin_edge_sync (
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   input wire logic i_pin,
   output logic o_level,
   output logic o_rise
);
   logic meta_reg; // first stage, read only by second
   logic sync_reg; // second stage, safe level
   logic last_reg; // previous safe level
   // synchroniser chain and edge history
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
      end else begin
         meta_reg <= i_pin;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end
   // level and one-cycle rising pulse
   assign o_level = sync_reg;
   assign o_rise = sync_reg & ~last_reg;
endmodule

// ===== hw/wake_prestart.sv
// module: raises the early mcu wake request ahead of the compare match
// assumes armed, timer and compare come from the same clock domain
`timescale 1ns/1ps
module wake_prestart (
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   input wire logic i_armed,
   input wire logic i_retention,
   input wire logic i_short_lead,
   input wire logic [15:0] i_timer,
   input wire logic [15:0] i_compare,
   output logic o_wake_req
);
   logic [15:0] remain; // periods left until match
   logic [15:0] lead; // chosen lead in periods
   logic wake_next; // next wake level
   logic wake_reg; // registered wake request
   // distance to match, wrap-around arithmetic
   always_comb begin
      remain = i_compare - i_timer;
      lead = i_short_lead ? rtc_wakeup_pkg::LEAD_SHORT : rtc_wakeup_pkg::LEAD_LONG;
      wake_next = i_armed & i_retention & (remain <= lead);
   end
   // registered request to the power controller
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wake_reg <= 1'b0;
      end else begin
         wake_reg <= wake_next;
      end
   end
   assign o_wake_req = wake_reg;
endmodule

// ===== verif/lf_radio_source.sv
// model: low-frequency clock source and radio interrupt line
// assumes the bench raises i_fire once for each radio interrupt edge
`timescale 1ns/1ps
module lf_radio_source (
   input wire logic i_fire,
   output logic o_low_freq_clock,
   output logic o_radio_irq
);
   // lf clock runs free, phase unrelated to the mcu clock
   initial begin
      o_low_freq_clock = 1'b0;
      o_radio_irq = 1'b0;
      #13;
      forever #(rtc_wakeup_pkg::LF_PERIOD_NS / 2) o_low_freq_clock = ~o_low_freq_clock;
   end
   // one radio interrupt edge per request, held a few hundred ns
   always @(posedge i_fire) begin
      o_radio_irq = 1'b1;
      #200;
      o_radio_irq = 1'b0;
   end
endmodule

// ===== verif/wakeup_timer_sva.sv
// checker: port-level properties of the wakeup timer
// assumes one clock domain and a bind onto the top module
`timescale 1ns/1ps
module wakeup_timer_sva (
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   input wire rtc_wakeup_pkg::sfr_req_s i_sfr,
   input wire logic [7:0] o_sfr_rdata,
   input wire logic o_sfr_hit,
   input wire logic i_low_freq_clock,
   input wire logic i_radio_irq,
   input wire rtc_wakeup_pkg::osc_status_s i_osc,
   input wire logic o_wakeup_irq,
   input wire logic o_wake_request,
   input wire logic o_rc_clock_select,
   input wire logic o_core_clock_run
);
   logic mapped; // address decodes to a register
   logic cfg_wr; // write to the config register
   logic cml_wr; // write to the low compare byte
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_arst_n);
   // address decode
   assign mapped = i_sfr.addr inside {8'hab, 8'hac, 8'hb3, 8'hb4, 8'hb5, 8'hb6};
   assign cfg_wr = i_sfr.wr && i_sfr.addr == rtc_wakeup_pkg::ADDR_RTC_CONFIG;
   assign cml_wr = i_sfr.wr && i_sfr.addr == rtc_wakeup_pkg::ADDR_COMPARE_LOW;
   hit_on_read_a: assert property (i_sfr.rd && mapped |=> o_sfr_hit)
      else $error("no hit after mapped read");
   unmapped_quiet_a: assert property (i_sfr.rd && !mapped |=> !o_sfr_hit && o_sfr_rdata == 8'h00)
      else $error("unmapped read answered");
   strobe_reads_zero_a: assert property (i_sfr.rd && i_sfr.addr == 8'hb3 |=> o_sfr_rdata[4] == 1'b0)
      else $error("trigger bit read back set");
   compare_readback_a: assert property (cml_wr ##1 !i_sfr.wr ##1 i_sfr.rd && i_sfr.addr == 8'hb4
      |=> o_sfr_rdata == $past(i_sfr.wdata, 3))
      else $error("compare byte not read back");
   core_run_follows_a: assert property (cfg_wr ##1 !cfg_wr |=> o_core_clock_run == $past(i_sfr.wdata[0], 2))
      else $error("core clock run differs from enable");
   idle_no_irq_a: assert property (!o_core_clock_run [*2] |-> !o_wakeup_irq)
      else $error("interrupt while disabled");
   irq_pulse_a: assert property (o_wakeup_irq |=> !o_wakeup_irq)
      else $error("interrupt longer than one cycle");
   wake_needs_ret_a: assert property (!i_osc.retention |=> !o_wake_request)
      else $error("wake request outside retention");
   rc_select_a: assert property (o_rc_clock_select == (o_wake_request && i_osc.clock_control[5:4] != 2'b00))
      else $error("rc select wrong");
endmodule
bind lowfreq_wakeup_timer_capture wakeup_timer_sva u_sva (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
   .i_sfr(i_sfr), .o_sfr_rdata(o_sfr_rdata), .o_sfr_hit(o_sfr_hit), .i_low_freq_clock(i_low_freq_clock),
   .i_radio_irq(i_radio_irq), .i_osc(i_osc), .o_wakeup_irq(o_wakeup_irq), .o_wake_request(o_wake_request),
   .o_rc_clock_select(o_rc_clock_select), .o_core_clock_run(o_core_clock_run));

// ===== verif/tb_lowfreq_wakeup_timer_capture.sv
// testbench: register, compare, capture and pre-start scenarios
// assumes the lf source model and the checker bound to the design
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin bad_count++; \
   $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb_lowfreq_wakeup_timer_capture;
   localparam int lf_cyc = rtc_wakeup_pkg::LF_PERIOD_NS / rtc_wakeup_pkg::SYS_PERIOD_NS; // cycles per lf period
   localparam logic [7:0] a_chi = rtc_wakeup_pkg::ADDR_CAPTURE_HIGH;
   localparam logic [7:0] a_cfi = rtc_wakeup_pkg::ADDR_CAPTURE_FINE;
   localparam logic [7:0] a_cfg = rtc_wakeup_pkg::ADDR_RTC_CONFIG;
   localparam logic [7:0] a_cml = rtc_wakeup_pkg::ADDR_COMPARE_LOW;
   localparam logic [7:0] a_cmh = rtc_wakeup_pkg::ADDR_COMPARE_HIGH;
   localparam logic [7:0] a_clo = rtc_wakeup_pkg::ADDR_CAPTURE_LOW;
   logic i_clk_sys = 1'b0;
   logic i_arst_n = 1'b0;
   rtc_wakeup_pkg::sfr_req_s i_sfr = '0;
   rtc_wakeup_pkg::osc_status_s i_osc = '0;
   logic radio_fire = 1'b0; // request to the radio model
   logic lf_clk, radio_irq, o_sfr_hit, o_wakeup_irq, o_wake_request, o_rc_clock_select, o_core_clock_run;
   logic [7:0] o_sfr_rdata, rd_data;
   logic rd_hit;
   int bad_count = 0;
   int total_checks = 0;
   int n, c;
   // 25 MHz clock
   always #20 i_clk_sys = ~i_clk_sys;
   lf_radio_source u_src (.i_fire(radio_fire), .o_low_freq_clock(lf_clk), .o_radio_irq(radio_irq));
   lowfreq_wakeup_timer_capture DUT (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_sfr(i_sfr),
      .o_sfr_rdata(o_sfr_rdata), .o_sfr_hit(o_sfr_hit), .i_low_freq_clock(lf_clk), .i_radio_irq(radio_irq),
      .i_osc(i_osc), .o_wakeup_irq(o_wakeup_irq), .o_wake_request(o_wake_request),
      .o_rc_clock_select(o_rc_clock_select), .o_core_clock_run(o_core_clock_run));
   // verdict and end of run
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // sfr write, one cycle strobe
   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clk_sys);
      i_sfr = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
      @(negedge i_clk_sys);
      i_sfr.wr = 1'b0;
   endtask
   // sfr read, answer taken the cycle after the strobe
   task automatic sfr_rd(input logic [7:0] a);
      @(negedge i_clk_sys);
      i_sfr = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(negedge i_clk_sys);
      rd_data = o_sfr_rdata;
      rd_hit = o_sfr_hit;
      i_sfr.rd = 1'b0;
   endtask
   task automatic chk_rd(input string nm, input logic [7:0] a, input logic [7:0] ex);
      sfr_rd(a);
      `CHK(nm, ex, rd_data)
   endtask
   // bounded wait for the next interrupt pulse
   task automatic wait_irq(input int bound, output int cnt);
      for (cnt = 1; cnt <= bound; cnt++) begin
         @(negedge i_clk_sys);
         if (o_wakeup_irq === 1'b1) return;
      end
      bad_count++;
      $display("Error wakeup irq expected 1 seen 0");
      report_and_stop();
   endtask
   task automatic count_irq(input int cyc, output int cnt);
      cnt = 0;
      repeat (cyc) begin
         @(negedge i_clk_sys);
         if (o_wakeup_irq === 1'b1) cnt++;
      end
   endtask
   task automatic pulse_radio();
      radio_fire = 1'b1;
      repeat (10) @(negedge i_clk_sys);
      radio_fire = 1'b0;
   endtask
   task automatic t_reset();
      chk_rd("capture_high", a_chi, 8'h00);
      chk_rd("capture_fine", a_cfi, 8'h00);
      chk_rd("capture_low", a_clo, 8'h00);
      chk_rd("rtc_config", a_cfg, 8'h00);
      chk_rd("compare_low", a_cml, 8'hff);
      chk_rd("compare_high", a_cmh, 8'hff);
      chk_rd("unmapped", 8'hb0, 8'h00);
      `CHK("unmapped hit", 1'b0, rd_hit)
      $display("test reset done");
   endtask
   task automatic t_regs();
      sfr_wr(a_cmh, 8'h12);
      sfr_wr(a_cml, 8'h34);
      chk_rd("compare_low", a_cml, 8'h34);
      chk_rd("compare_high", a_cmh, 8'h12);
      sfr_wr(a_clo, 8'h55);
      chk_rd("capture_low write", a_clo, 8'h00);
      sfr_wr(a_cfg, 8'h0e);
      chk_rd("rtc_config", a_cfg, 8'h0e);
      `CHK("core run off", 1'b0, o_core_clock_run)
      sfr_wr(a_cfg, 8'h1e);
      chk_rd("trigger bit", a_cfg, 8'h0e);
      chk_rd("held timer capture", a_clo, 8'h00);
      sfr_wr(a_cfg, 8'h01);
      @(negedge i_clk_sys);
      `CHK("core run on", 1'b1, o_core_clock_run)
      $display("test regs done");
   endtask
   task automatic t_mode11();
      sfr_wr(a_cfg, 8'h00);
      sfr_wr(a_cml, 8'h02);
      sfr_wr(a_cmh, 8'h00);
      sfr_wr(a_cfg, 8'h07);
      wait_irq(4 * lf_cyc, n);
      `CHK("first irq lag", 1'b1, n >= 2 * lf_cyc && n <= 3 * lf_cyc + 4)
      wait_irq(4 * lf_cyc, n);
      `CHK("irq period", 3 * lf_cyc, n)
      $display("test mode11 done");
   endtask
   task automatic t_capture();
      wait_irq(4 * lf_cyc, n);
      repeat (lf_cyc + 300) @(negedge i_clk_sys);
      sfr_wr(a_cfg, 8'h17);
      chk_rd("soft capture low", a_clo, 8'h01);
      chk_rd("soft capture high", a_chi, 8'h00);
      sfr_rd(a_cfi);
      `CHK("fine count", 1'b1, rd_data >= 8'h94 && rd_data <= 8'h9a)
      $display("test capture done");
   endtask
   task automatic t_radio();
      wait_irq(4 * lf_cyc, n);
      sfr_wr(a_cfg, 8'h07);
      repeat (lf_cyc + 100) @(negedge i_clk_sys);
      pulse_radio();
      chk_rd("radio disabled", a_clo, 8'h01);
      repeat (lf_cyc) @(negedge i_clk_sys);
      sfr_wr(a_cfg, 8'h0f);
      pulse_radio();
      chk_rd("radio capture low", a_clo, 8'h02);
      chk_rd("radio capture high", a_chi, 8'h00);
      sfr_rd(a_cfi);
      `CHK("radio fine", 1'b1, rd_data >= 8'h38 && rd_data <= 8'h40)
      $display("test radio done");
   endtask
   task automatic t_modes();
      sfr_wr(a_cfg, 8'h00);
      sfr_wr(a_cml, 8'h01);
      sfr_wr(a_cfg, 8'h05);
      wait_irq(3 * lf_cyc, n);
      count_irq(4 * lf_cyc, c);
      `CHK("mode 10 no reset", 0, c)
      for (int i = 0; i < 2; i++) begin
         sfr_wr(a_cfg, 8'h00);
         sfr_wr(a_cfg, (i == 0) ? 8'h01 : 8'h03);
         count_irq(4 * lf_cyc, c);
         `CHK("mode 0x silent", 0, c)
      end
      $display("test modes done");
   endtask
   task automatic t_wake(input logic [7:0] cc, input logic xe, input logic xr, input logic [7:0] cmp,
      input int lo, input int hi, input logic rc);
      int w;
      int q;
      w = -1;
      q = -1;
      sfr_wr(a_cfg, 8'h00);
      sfr_wr(a_cml, cmp);
      sfr_wr(a_cmh, 8'h00);
      i_osc = '{retention: 1'b1, xtal_enabled: xe, xtal_running: xr, clock_control: cc};
      sfr_wr(a_cfg, 8'h07);
      for (int i = 0; i < 60 * lf_cyc && q < 0; i++) begin
         @(negedge i_clk_sys);
         if (o_wake_request === 1'b1 && w < 0) begin
            w = i;
            `CHK("rc select", rc, o_rc_clock_select)
         end
         if (o_wakeup_irq === 1'b1) q = i;
      end
      `CHK("wake lead", 1'b1, w >= 0 && q - w >= lo && q - w <= hi)
      if (q < 0) report_and_stop();
      i_osc.retention = 1'b0;
      $display("test wake done");
   endtask
   // main sequence
   initial begin
      repeat (20) @(negedge i_clk_sys);
      i_arst_n = 1'b1;
      t_reset();
      t_regs();
      t_mode11();
      t_capture();
      t_radio();
      t_modes();
      t_wake(8'h10, 1'b0, 1'b0, 8'h08, 2 * lf_cyc, 3 * lf_cyc + 4, 1'b1);
      t_wake(8'h80, 1'b1, 1'b1, 8'h08, 2 * lf_cyc, 3 * lf_cyc + 4, 1'b0);
      t_wake(8'h00, 1'b1, 1'b0, 8'h33, 49 * lf_cyc, 50 * lf_cyc + 4, 1'b0);
      report_and_stop();
   end
endmodule
